// [rtl/sriod_pkg.sv]
// package of constants for the script i/o and register-op decoder
package sriod_pkg;
  // instruction field positions
  localparam int OPC_HI        = 29;
  localparam int OPC_LO        = 27;
  localparam int RA_BIT        = 26;
  localparam int TI_BIT        = 25;
  localparam int SEL_ATN_BIT   = 24;
  localparam int FB_BIT        = 23;
  localparam int TARGET_ID_FIELD_HI      = 19;
  localparam int TARGET_ID_FIELD_LO      = 16;
  localparam int CA_POS        = 10;
  localparam int TM_POS        = 9;
  localparam int ACK_POS       = 6;
  localparam int ATN_POS       = 3;
  localparam int IMM_HI        = 15;
  localparam int IMM_LO        = 8;
  localparam int ADDR_HI       = 22;
  localparam int ADDR_LO       = 16;
  localparam int OFS_HI        = 23;
  // opcode encodings
  localparam logic [2:0] OPC_SELECT   = 3'h0;
  localparam logic [2:0] OPC_WAIT_DIS = 3'h1;
  localparam logic [2:0] OPC_WAIT_RES = 3'h2;
  localparam logic [2:0] OPC_SET      = 3'h3;
  localparam logic [2:0] OPC_CLEAR    = 3'h4;
  localparam logic [2:0] OPC_IO_MAX   = 3'h4;
  // operator encodings
  localparam logic [2:0] OP_MOVE = 3'h0;
  localparam logic [2:0] OP_SHL  = 3'h1;
  localparam logic [2:0] OP_OR   = 3'h2;
  localparam logic [2:0] OP_XOR  = 3'h3;
  localparam logic [2:0] OP_AND  = 3'h4;
  localparam logic [2:0] OP_SHR  = 3'h5;
  localparam logic [2:0] OP_ADD  = 3'h6;
  localparam logic [2:0] OP_ADC  = 3'h7;
  // timing
  localparam int CLK_PERIOD_NS   = 50;
  localparam int BUS_FREE_NS     = 400;
  localparam int BUS_FREE_CYC    = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] BUS_FREE_CNT = 4'(BUS_FREE_CYC);
  // state codes
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SEL  = 5'h02,
    ST_WDIS = 5'h04,
    ST_WRES = 5'h08,
    ST_DONE = 5'h10
  } sriod_state_e;
endpackage

// [rtl/sriod_decoder.sv]
// script i/o and register-operation decode and execute
`timescale 1ns/10ps
module sriod_decoder
  import sriod_pkg::*;
(
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        INSTR_VALID_IN,       // one-cycle: new instruction
  input  wire logic [31:0] INSTR_WORD0_IN,
  input  wire logic [31:0] NEXT_ADDR_REG_IN,     // second dword
  input  wire logic [31:0] SCRIPT_PTR_IN,
  input  wire logic [31:0] DATA_STRUCT_BASE_IN,
  input  wire logic        REGISTER_OP_ENABLE_IN,
  input  wire logic        CPU_SIGNAL_FLAG_IN,
  input  wire logic        ARB_WON_IN,           // pulse
  input  wire logic        SELECTED_IN,          // pulse
  input  wire logic        RESELECTED_IN,        // pulse
  input  wire logic        DISC_MSG_IN,          // pulse: disconnect/complete message
  input  wire logic        BUS_BUSY_LINE_IN,     // pin, active high
  input  wire logic        BUS_SEL_LINE_IN,      // pin, active high
  input  wire logic [7:0]  FIRST_BYTE_REG_IN,
  input  wire logic [7:0]  REG_RDATA_IN,         // value of addressed register
  output logic             DONE_OUT,             // one-cycle completion
  output logic             JUMP_ALT_OUT,         // with done: take jump target
  output logic [31:0]      JUMP_ADDR_OUT,
  output logic             ILLEGAL_OUT,          // one-cycle
  output logic             ARB_REQ_OUT,
  output logic             SEL_ATN_OUT,
  output logic [3:0]       TARGET_ID_FIELD_OUT,
  output logic             TABLE_FETCH_OUT,      // one-cycle
  output logic [31:0]      TABLE_ADDR_OUT,
  output logic             TARGET_ROLE_BIT_OUT,
  output logic             ALU_FLAG_BIT_OUT,
  output logic [7:0]       SCSI_OUT_LATCH_OUT,
  output logic             BUS_ACK_LINE_OUT,
  output logic             BUS_ATTENTION_LINE_OUT,
  output logic             REG_WE_OUT,           // one-cycle
  output logic [7:0]       REG_ADDR_OUT,
  output logic [7:0]       REG_WDATA_OUT,
  output logic             FB_WE_OUT,            // one-cycle: write first byte reg
  output logic [7:0]       FB_WDATA_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers for bus lines
  logic [2:0] bsy_sync_r, sel_sync_r;
  logic       bsy_q_r, sel_q_r;
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      bsy_sync_r <= 3'h0;
      sel_sync_r <= 3'h0;
      bsy_q_r    <= 1'b0;
      sel_q_r    <= 1'b0;
    end
    else
    begin
      bsy_sync_r <= {bsy_sync_r[1:0], BUS_BUSY_LINE_IN};
      sel_sync_r <= {sel_sync_r[1:0], BUS_SEL_LINE_IN};
      if (bsy_sync_r[1] == bsy_sync_r[2]) bsy_q_r <= bsy_sync_r[2];
      if (sel_sync_r[1] == sel_sync_r[2]) sel_q_r <= sel_sync_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field decode
  logic [2:0]  operation_field, oper;
  logic        is_io;
  logic [7:0]  imm, operand2;
  logic [31:0] rel_target, alt_target;
  assign operation_field   = INSTR_WORD0_IN[OPC_HI:OPC_LO];
  assign oper  = INSTR_WORD0_IN[26:24];
  assign is_io = (operation_field <= OPC_IO_MAX);
  assign imm   = INSTR_WORD0_IN[IMM_HI:IMM_LO];
  assign operand2 = INSTR_WORD0_IN[FB_BIT] ? FIRST_BYTE_REG_IN : imm;
  assign rel_target = SCRIPT_PTR_IN + {{8{NEXT_ADDR_REG_IN[23]}}, NEXT_ADDR_REG_IN[23:0]};
  assign alt_target = INSTR_WORD0_IN[RA_BIT] ? rel_target : NEXT_ADDR_REG_IN;

  ////////////////////////////////////////////////////////////////////////////
  // alu for register operations
  logic [7:0] alu_res, alu_a;
  logic       alu_cy;
  // operator decode, shifts go through carry
  always_comb
  begin
    alu_a  = (operation_field == 3'h5) ? FIRST_BYTE_REG_IN : REG_RDATA_IN;
    alu_cy = ALU_FLAG_BIT_OUT;
    case (oper)
      OP_MOVE: alu_res = operand2;
      OP_SHL:  {alu_cy, alu_res} = {alu_a, ALU_FLAG_BIT_OUT};
      OP_OR:   alu_res = alu_a | operand2;
      OP_XOR:  alu_res = alu_a ^ operand2;
      OP_AND:  alu_res = alu_a & operand2;
      OP_SHR:  {alu_res, alu_cy} = {ALU_FLAG_BIT_OUT, alu_a};
      OP_ADD:  {alu_cy, alu_res} = {1'b0, alu_a} + {1'b0, operand2};
      default: {alu_cy, alu_res} = {1'b0, alu_a} + {1'b0, operand2} + {8'h00, ALU_FLAG_BIT_OUT};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state
  sriod_state_e state_r, state_nxt;
  logic [31:0]  alt_r, alt_nxt;
  logic         atn_sel_r, atn_sel_nxt, msg_r, msg_nxt;
  logic [3:0]   free_cnt_r, free_cnt_nxt, id_r, id_nxt;
  logic         jump_r, jump_nxt;
  logic         done_nxt, ill_nxt, tf_nxt, we_nxt, fbwe_nxt, done_r, ill_r, tf_r, we_r, fbwe_r;
  logic [31:0]  taddr_r, taddr_nxt;
  logic         tm_r, tm_nxt, ca_r, ca_nxt;
  logic [7:0]   latch_r, latch_nxt;
  logic [7:0]   raddr_r, raddr_nxt, wdata_r, wdata_nxt, fbdata_r, fbdata_nxt;

  // next state, held values and one-cycle strobes
  always_comb
  begin
    state_nxt = state_r;
    {alt_nxt, atn_sel_nxt, msg_nxt, free_cnt_nxt, jump_nxt, id_nxt, taddr_nxt, tm_nxt}
      = {alt_r, atn_sel_r, msg_r, free_cnt_r, jump_r, id_r, taddr_r, tm_r};
    {ca_nxt, latch_nxt, raddr_nxt, wdata_nxt, fbdata_nxt}
      = {ca_r, latch_r, raddr_r, wdata_r, fbdata_r};
    {done_nxt, ill_nxt, tf_nxt, we_nxt, fbwe_nxt} = 5'h00;
    case (state_r)
      ST_IDLE:
      begin
        jump_nxt = 1'b0;
        if (INSTR_VALID_IN && is_io)
        begin
          alt_nxt = alt_target;
          id_nxt  = INSTR_WORD0_IN[TARGET_ID_FIELD_HI:TARGET_ID_FIELD_LO];
          if (INSTR_WORD0_IN[TI_BIT])
          begin
            tf_nxt    = 1'b1;
            taddr_nxt = DATA_STRUCT_BASE_IN
                      + {{8{INSTR_WORD0_IN[OFS_HI]}}, INSTR_WORD0_IN[OFS_HI:0]};
          end
          // attention bit only legal on select
          if (INSTR_WORD0_IN[SEL_ATN_BIT] && operation_field != OPC_SELECT)
          begin
            ill_nxt  = 1'b1;
            done_nxt = 1'b1;
          end
          else
          begin
            case (operation_field)
              OPC_SELECT:
              begin
                atn_sel_nxt = INSTR_WORD0_IN[SEL_ATN_BIT];
                state_nxt   = ST_SEL;
              end
              OPC_WAIT_DIS:
              begin
                msg_nxt      = 1'b0;
                free_cnt_nxt = 4'h0;
                state_nxt    = ST_WDIS;
              end
              OPC_WAIT_RES: state_nxt = ST_WRES;
              default:
              begin
                if (INSTR_WORD0_IN[TM_POS]) tm_nxt = (operation_field == OPC_SET);
                if (INSTR_WORD0_IN[CA_POS]) ca_nxt = (operation_field == OPC_SET);
                if (INSTR_WORD0_IN[ACK_POS]) latch_nxt[ACK_POS] = (operation_field == OPC_SET);
                if (INSTR_WORD0_IN[ATN_POS]) latch_nxt[ATN_POS] = (operation_field == OPC_SET);
                done_nxt = 1'b1;
              end
            endcase
          end
        end
        else if (INSTR_VALID_IN)
        begin
          if (REGISTER_OP_ENABLE_IN)
          begin
            raddr_nxt = {INSTR_WORD0_IN[7], INSTR_WORD0_IN[ADDR_HI:ADDR_LO]};
            if (oper == OP_SHL || oper == OP_SHR || oper[2:1] == 2'h3) ca_nxt = alu_cy;
            fbwe_nxt = (operation_field == 3'h6);
            we_nxt   = (operation_field != 3'h6);
            if (operation_field == 3'h6) fbdata_nxt = alu_res;
            if (operation_field != 3'h6) wdata_nxt = alu_res;
          end
          else
            ill_nxt = 1'b1;
          done_nxt = 1'b1;
        end
      end
      ST_SEL:
      begin
        if (SELECTED_IN || RESELECTED_IN || ARB_WON_IN)
        begin
          jump_nxt  = SELECTED_IN || RESELECTED_IN;
          done_nxt  = 1'b1;
          state_nxt = ST_DONE;
        end
      end
      ST_WDIS:
      begin
        // message then bus free for 400ns
        if (DISC_MSG_IN) msg_nxt = 1'b1;
        if (bsy_q_r || sel_q_r || !msg_r)
          free_cnt_nxt = 4'h0;
        else if (free_cnt_r == BUS_FREE_CNT - 4'h1)
        begin
          done_nxt  = 1'b1;
          state_nxt = ST_DONE;
        end
        else
          free_cnt_nxt = free_cnt_r + 4'h1;
      end
      ST_WRES:
      begin
        if (SELECTED_IN || CPU_SIGNAL_FLAG_IN || RESELECTED_IN)
        begin
          jump_nxt  = SELECTED_IN || CPU_SIGNAL_FLAG_IN;
          done_nxt  = 1'b1;
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      state_r <= ST_IDLE;
      {alt_r, atn_sel_r, msg_r, free_cnt_r, jump_r, id_r, taddr_r, tm_r} <= 76'h0;
      {ca_r, latch_r, raddr_r, wdata_r, fbdata_r} <= 33'h0;
      {done_r, ill_r, tf_r, we_r, fbwe_r} <= 5'h00;
    end
    else
    begin
      state_r <= state_nxt;
      {alt_r, atn_sel_r, msg_r, free_cnt_r, jump_r, id_r, taddr_r, tm_r}
        <= {alt_nxt, atn_sel_nxt, msg_nxt, free_cnt_nxt, jump_nxt, id_nxt, taddr_nxt, tm_nxt};
      {ca_r, latch_r, raddr_r, wdata_r, fbdata_r}
        <= {ca_nxt, latch_nxt, raddr_nxt, wdata_nxt, fbdata_nxt};
      {done_r, ill_r, tf_r, we_r, fbwe_r} <= {done_nxt, ill_nxt, tf_nxt, we_nxt, fbwe_nxt};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign DONE_OUT            = done_r;
  assign JUMP_ALT_OUT        = jump_r;
  assign JUMP_ADDR_OUT       = alt_r;
  assign ILLEGAL_OUT         = ill_r;
  assign ARB_REQ_OUT         = (state_r == ST_SEL);
  assign SEL_ATN_OUT         = (state_r == ST_SEL) && atn_sel_r;
  assign TARGET_ID_FIELD_OUT = id_r;
  assign TABLE_FETCH_OUT     = tf_r;
  assign TABLE_ADDR_OUT      = taddr_r;
  assign TARGET_ROLE_BIT_OUT = tm_r;
  assign ALU_FLAG_BIT_OUT    = ca_r;
  assign SCSI_OUT_LATCH_OUT  = latch_r;
  // target mode keeps initiator lines off
  assign BUS_ACK_LINE_OUT       = latch_r[ACK_POS] && !tm_r;
  assign BUS_ATTENTION_LINE_OUT = (latch_r[ATN_POS] || SEL_ATN_OUT) && !tm_r;
  assign REG_WE_OUT    = we_r;
  assign REG_ADDR_OUT  = raddr_r;
  assign REG_WDATA_OUT = wdata_r;
  assign FB_WE_OUT     = fbwe_r;
  assign FB_WDATA_OUT  = fbdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  illegal_atn_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    state_r == ST_IDLE && INSTR_VALID_IN && is_io && INSTR_WORD0_IN[SEL_ATN_BIT]
    && operation_field != OPC_SELECT |=> ILLEGAL_OUT && DONE_OUT) else $error("no illegal flag");
  target_lines_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    TARGET_ROLE_BIT_OUT |-> !BUS_ACK_LINE_OUT && !BUS_ATTENTION_LINE_OUT)
    else $error("target drives initiator line");
  sel_preempt_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    state_r == ST_SEL && (SELECTED_IN || RESELECTED_IN) |=> DONE_OUT && JUMP_ALT_OUT)
    else $error("select preempt not jumped");
  wres_seq_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    state_r == ST_WRES && RESELECTED_IN && !SELECTED_IN && !CPU_SIGNAL_FLAG_IN
    |=> DONE_OUT && !JUMP_ALT_OUT) else $error("reselect not sequential");
  wres_abort_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    state_r == ST_WRES && CPU_SIGNAL_FLAG_IN |=> DONE_OUT && JUMP_ALT_OUT)
    else $error("abort not taken");
  wdis_free_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    state_r == ST_WDIS && DONE_OUT == 1'b0 ##1 state_r == ST_DONE
    |-> $past(free_cnt_r) == BUS_FREE_CNT - 4'h1) else $error("bus free too short");
  carry_set_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    state_r == ST_IDLE && INSTR_VALID_IN && operation_field == OPC_SET
    && !INSTR_WORD0_IN[SEL_ATN_BIT] && INSTR_WORD0_IN[CA_POS] |=> ALU_FLAG_BIT_OUT)
    else $error("carry not set");
  regop_gate_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    state_r == ST_IDLE && INSTR_VALID_IN && !is_io && !REGISTER_OP_ENABLE_IN
    |=> !REG_WE_OUT && !FB_WE_OUT) else $error("register op while disabled");
  sel_done_c: cover property (@(posedge CLK_SYS_IN) state_r == ST_SEL && ARB_WON_IN);
  wdis_done_c: cover property (@(posedge CLK_SYS_IN) state_r == ST_WDIS && done_nxt);
  wres_jump_c: cover property (@(posedge CLK_SYS_IN) state_r == ST_WRES && SELECTED_IN);
  regop_c: cover property (@(posedge CLK_SYS_IN) REG_WE_OUT);
endmodule // sriod_decoder

// [verif/sriod_bus_model.sv]
// bus-side partner model: arbitration, selection and disconnect events
`timescale 1ns/10ps
module sriod_bus_model
(
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       go_in,
  input  wire logic [1:0] mode_in,
  input  wire logic [7:0] delay_in,
  output logic            arb_won_out,
  output logic            selected_out,
  output logic            reselected_out,
  output logic            disc_msg_out,
  output logic            busy_out,
  output logic            sel_out
);
  logic       pend_r;
  logic [7:0] cnt_r;
  logic       fire;

  ////////////////////////////////////////////////////////////////////////////
  // event fires once the programmed delay has run out
  assign fire    = pend_r && (cnt_r == 8'h00);
  // another device drives select while it selects or reselects us
  assign sel_out = pend_r && ((mode_in == 2'h1) || (mode_in == 2'h2));

  // delay count, one-cycle event pulses, busy while connected
  always @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      pend_r   <= 1'b0;
      cnt_r    <= 8'h00;
      busy_out <= 1'b0;
    end
    else if (go_in)
    begin
      pend_r <= 1'b1;
      cnt_r  <= delay_in;
    end
    else if (fire)
      pend_r <= 1'b0;
    else if (pend_r)
      cnt_r <= cnt_r - 8'h01;
    if (rst_n_in && fire && (mode_in != 2'h3))
      busy_out <= 1'b1;
    else if (rst_n_in && disc_msg_out)
      busy_out <= 1'b0; // released lines go inactive
    arb_won_out    <= rst_n_in && fire && (mode_in == 2'h0);
    selected_out   <= rst_n_in && fire && (mode_in == 2'h1);
    reselected_out <= rst_n_in && fire && (mode_in == 2'h2);
    disc_msg_out   <= rst_n_in && fire && (mode_in == 2'h3);
  end
endmodule // sriod_bus_model

// [verif/tb_sriod_decoder.sv]
// self-checking testbench of the script i/o and register-op decoder
`timescale 1ns/10ps
module tb_sriod_decoder
  import sriod_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        valid = 1'b0;
  logic [31:0] w0 = 32'h0;
  logic [31:0] nxt = 32'h0;
  logic [31:0] ptr = 32'h0000_1000;
  logic [31:0] base = 32'h0010_0000;
  logic        reg_en = 1'b0;
  logic        cpu_flag = 1'b0;
  logic [7:0]  fb_val = 8'h3C;
  logic [7:0]  rdata = 8'hC3;
  logic        go = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic [7:0]  dly = 8'h03;
  logic        arb_won, selected, reselected, disc_msg, busy, sel;
  logic        done, alt, illegal, arb_req, sel_atn, tfetch, role, carry_o, ack, atn;
  logic        reg_we, fb_we;
  logic [31:0] jaddr, taddr;
  logic [3:0]  tid;
  logic [7:0]  latch, raddr, wdata, fbdata;
  logic        we_seen, fb_seen, tf_seen;
  logic [7:0]  seen_addr, seen_data;
  logic [31:0] tf_addr;
  logic        carry;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          k;

  ////////////////////////////////////////////////////////////////////////////
  // clock at 20 MHz
  always #25 clk = ~clk;

  sriod_decoder i_sriod_decoder (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .INSTR_VALID_IN(valid),
    .INSTR_WORD0_IN(w0), .NEXT_ADDR_REG_IN(nxt), .SCRIPT_PTR_IN(ptr),
    .DATA_STRUCT_BASE_IN(base), .REGISTER_OP_ENABLE_IN(reg_en), .CPU_SIGNAL_FLAG_IN(cpu_flag),
    .ARB_WON_IN(arb_won), .SELECTED_IN(selected), .RESELECTED_IN(reselected),
    .DISC_MSG_IN(disc_msg), .BUS_BUSY_LINE_IN(busy), .BUS_SEL_LINE_IN(sel),
    .FIRST_BYTE_REG_IN(fb_val), .REG_RDATA_IN(rdata), .DONE_OUT(done), .JUMP_ALT_OUT(alt),
    .JUMP_ADDR_OUT(jaddr), .ILLEGAL_OUT(illegal), .ARB_REQ_OUT(arb_req),
    .SEL_ATN_OUT(sel_atn), .TARGET_ID_FIELD_OUT(tid), .TABLE_FETCH_OUT(tfetch),
    .TABLE_ADDR_OUT(taddr), .TARGET_ROLE_BIT_OUT(role), .ALU_FLAG_BIT_OUT(carry_o),
    .SCSI_OUT_LATCH_OUT(latch), .BUS_ACK_LINE_OUT(ack), .BUS_ATTENTION_LINE_OUT(atn),
    .REG_WE_OUT(reg_we), .REG_ADDR_OUT(raddr), .REG_WDATA_OUT(wdata), .FB_WE_OUT(fb_we),
    .FB_WDATA_OUT(fbdata));

  sriod_bus_model i_sriod_bus_model (.clk_in(clk), .rst_n_in(rst_n), .go_in(go),
    .mode_in(mode), .delay_in(dly), .arb_won_out(arb_won), .selected_out(selected),
    .reselected_out(reselected), .disc_msg_out(disc_msg), .busy_out(busy), .sel_out(sel));

  // capture of one-cycle write and fetch strobes
  always @(posedge clk)
  begin
    if (reg_we)
      {we_seen, seen_addr, seen_data} <= {1'b1, raddr, wdata};
    if (fb_we)
      {fb_seen, seen_data} <= {1'b1, fbdata};
    if (tfetch)
      {tf_seen, tf_addr} <= {1'b1, taddr};
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // one instruction, two idle cycles ahead of it
  task automatic issue(input logic [31:0] w, input logic [31:0] n);
    repeat (2) @(negedge clk);
    {w0, nxt, valid} = {w, n, 1'b1};
    {we_seen, fb_seen, tf_seen} = 3'b000;
    @(negedge clk);
    valid = 1'b0;
  endtask

  task automatic wait_done(output int n);
    n = 0;
    while (done !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 300)
    begin
      n_mismatch++;
      $display("MISMATCH %0t no completion", $time);
      finish_test();
    end
  endtask

  function automatic logic [31:0] sext(input logic [23:0] x);
    return {{8{x[23]}}, x};
  endfunction

  // select or wait reselect with one bus event (4 means cpu flag)
  task automatic io_case(input logic [31:0] w, input logic [31:0] n, input logic [2:0] m,
                         input logic exp_alt, input logic [31:0] exp_addr);
    issue(w, n);
    if (w[29:27] == OPC_SELECT)
    begin
      check(arb_req, 1'b1, "arb request");
      check(sel_atn, w[24], "select atn");
      if (!w[25])
        check(tid, w[19:16], "target id");
    end
    if (m == 3'h4)
      cpu_flag = 1'b1;
    else
    begin
      {mode, dly, go} = {m[1:0], 8'h03, 1'b1};
      @(negedge clk);
      go = 1'b0;
    end
    wait_done(k);
    check(alt, exp_alt, "alternate jump");
    if (exp_alt)
      check(jaddr, exp_addr, "jump address");
    if (w[25])
      check({tf_seen, tf_addr}, {1'b1, base + sext(w[23:0])}, "table addr");
    cpu_flag = 1'b0;
  endtask

  // set or clear, then the role, carry and latch state
  task automatic sc(input logic [31:0] w, input logic [12:0] exp);
    issue(w, 32'h0);
    wait_done(k);
    check(illegal, w[24], "illegal flag");
    carry = exp[11];
    check({role, carry_o, latch, ack, atn, 1'b0}, exp, "set clear");
  endtask

  function automatic logic [8:0] alu(input logic [2:0] op, input logic [7:0] a,
                                     input logic [7:0] b, input logic c);
    case (op)
      OP_MOVE: return {c, b};
      OP_SHL:  return {a, c};
      OP_OR:   return {c, a | b};
      OP_XOR:  return {c, a ^ b};
      OP_AND:  return {c, a & b};
      OP_SHR:  return {a[0], c, a[7:1]};
      OP_ADD:  return {1'b0, a} + {1'b0, b};
      default: return {1'b0, a} + {1'b0, b} + {8'h00, c};
    endcase
  endfunction

  task automatic regop(input logic [2:0] operation_field, input logic [2:0] op, input logic d8);
    logic [8:0] r;
    r = alu(op, (operation_field == 3'h5) ? fb_val : rdata, d8 ? fb_val : 8'h81, carry);
    issue({2'b01, operation_field, op, d8, 7'h15, 8'h81, 8'h80}, 32'h0);
    wait_done(k);
    @(negedge clk); // strobes are captured one edge later
    carry = r[8];
    if (operation_field == 3'h6)
      check({fb_seen, seen_data}, {1'b1, r[7:0]}, "first byte write");
    else
      check({we_seen, seen_addr, seen_data}, {1'b1, 8'h95, r[7:0]}, "reg write");
    check(carry_o, carry, "carry");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check({done, role, latch}, 10'h0, "reset state");
    // set all plus a reserved bit, then clear piece by piece
    sc(32'h5800_0748, {2'b11, 8'h48, 3'b000});
    sc(32'h6000_0200, {2'b01, 8'h48, 3'b110});
    sc(32'h6000_0440, {2'b00, 8'h08, 3'b010});
    sc(32'h6000_0008, {2'b00, 8'h00, 3'b000});
    sc(32'h5900_0000, {2'b00, 8'h00, 3'b000});
    io_case(32'h4105_0000, 32'h0000_2400, 3'h0, 1'b0, 32'h0);
    io_case(32'h4003_0000, 32'h0000_2400, 3'h1, 1'b1, 32'h0000_2400);
    io_case(32'h4403_0000, 32'h00FF_FF00, 3'h2, 1'b1, 32'h0000_0F00);
    io_case(32'h5002_0000, 32'h0000_2400, 3'h2, 1'b0, 32'h0);
    io_case(32'h5002_0000, 32'h0000_2400, 3'h1, 1'b1, 32'h0000_2400);
    io_case(32'h5402_0000, 32'h00FF_FF00, 3'h4, 1'b1, 32'h0000_0F00);
    // dword offset keeps the four-byte entry whole
    io_case(32'h42FF_FFF0, 32'h0000_2400, 3'h0, 1'b0, 32'h0);
    io_case(32'h4600_0040, 32'h00FF_FF00, 3'h1, 1'b1, 32'h0000_0F00);
    // wait disconnect: message late, then bus free
    issue(32'h4800_0000, 32'h0);
    {mode, dly, go} = {2'h3, 8'h14, 1'b1};
    @(negedge clk);
    go = 1'b0;
    wait_done(k);
    check(k >= 31 && k <= 36, 1'b1, "bus free wait");
    // register operations refused while disabled
    issue(32'h7815_8180, 32'h0);
    wait_done(k);
    check({illegal, reg_we, fb_we}, 3'b100, "disabled regop");
    reg_en = 1'b1;
    for (int op = 0; op < 8; op++)
      regop(3'h7, op[2:0], op == 6);
    regop(3'h6, OP_OR, 1'b0);
    regop(3'h5, OP_XOR, 1'b0);
    finish_test();
  end
endmodule // tb_sriod_decoder
